/* File: spi_frame_pkg.sv */
// Shared constants and types for the framed serial access link
// Function
// - Device is slave, modes 0 and 3
// - Sample on rising, shift on falling
// - Either clock idle level accepted
// - Master holds select high between frames
// - Select falling edge starts new header
// - Header: address high, low, flag, count
// - Third byte: flag bit, count high bits
// - Flag 0 reads, flag 1 writes
// - Count one single, larger count burst
// - Read: dummy out, data byte back
// - Write: data bytes follow header, stored
// - Device drives data-out low after select
// - Master drives data-in low before header
// - Data-out released while select high
// - Single read: address, flag 0, count, byte
// - Single write: address, flag 1, count, byte
package spi_frame_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W       = 16;
  localparam int COUNT_W      = 15;
  localparam int BYTE_W       = 8;
  localparam int HDR_BYTES    = 4;
  localparam int DIR_BIT      = 7;
  localparam logic DIR_READ   = 1'b0;
  localparam logic DIR_WRITE  = 1'b1;
  localparam logic [1:0] HDR_ADDR_HI = 2'h0;
  localparam logic [1:0] HDR_ADDR_LO = 2'h1;
  localparam logic [1:0] HDR_FLAG_CNT = 2'h2;
  localparam logic [1:0] HDR_CNT_LO  = 2'h3;

  // ----------------------------------------------------------------
  // Timing and FIFO depth
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 5;
  localparam int SCLK_PERIOD_NS    = 80;
  localparam int SCLK_HALF_CYCLES  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int FIFO_DEPTH_WORDS  = 16;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    DEV_HDR  = 2'b00,
    DEV_DATA = 2'b01,
    DEV_DONE = 2'b10
  } dev_state_t;

  typedef enum logic [2:0]
  {
    HOST_IDLE  = 3'b000,
    HOST_SETUP = 3'b001,
    HOST_LOAD  = 3'b010,
    HOST_LOW   = 3'b011,
    HOST_HIGH  = 3'b100,
    HOST_END   = 3'b101
  } host_state_t;

endpackage

/* File: spi_frame_if.sv */
// Four-wire link between the access master and the slave device
`timescale 1ns/1ps
interface spi_frame_if;
  logic slave_select_low;
  logic serial_clk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Released line floats high through a modelled pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport device
  (
    input  slave_select_low,
    input  serial_clk,
    input  mosi,
    output miso,
    output miso_oe
  );

  modport host
  (
    output slave_select_low,
    output serial_clk,
    output mosi,
    input  miso_line
  );
endinterface

/* File: spi_frame_host.sv */
// Access master end with its write-data FIFO
`timescale 1ns/1ps
module spi_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr    <= wr_ptr + AW'(push);
      rd_ptr    <= rd_ptr + AW'(pop);
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

module spi_frame_host import spi_frame_pkg::*; #(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES,
  parameter bit MODE3       = 1'b0,
  parameter int FIFO_DEPTH  = FIFO_DEPTH_WORDS
)(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  spi_frame_if.host               link,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic [ADDR_W-1:0]  cmd_addr,
  input  wire logic               cmd_direction_flag,
  input  wire logic [COUNT_W-1:0] cmd_count,
  input  wire logic               wr_valid,
  output logic                    wr_ready,
  input  wire logic [BYTE_W-1:0]  wr_data,
  output logic [BYTE_W-1:0]       rd_data,
  output logic                    rd_valid,
  output logic                    done
);
  host_state_t       state;
  logic [31:0]       hdr;
  logic [15:0]       byte_pos;
  logic [15:0]       last_pos;
  logic [2:0]        bit_idx;
  logic [7:0]        tx;
  logic [6:0]        rx;
  logic [7:0]        div;
  logic              miso_s1;
  logic              miso_s2;
  logic              f_valid;
  logic              f_pop;
  logic [7:0]        f_data;
  logic              in_data;
  logic              is_write;
  logic [7:0]        new_byte;

  spi_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .sys_rst(sys_rst), .in_valid(wr_valid), .in_ready(wr_ready), .in_data(wr_data),
    .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data)
  );

  // ----------------------------------------------------------------
  // Link input sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    miso_s1 <= link.miso_line;
    miso_s2 <= miso_s1;
  end

  assign in_data  = byte_pos >= 16'(HDR_BYTES);
  assign is_write = hdr[15] == DIR_WRITE;
  assign new_byte = !in_data ? hdr[31 - 8*byte_pos[1:0] -: 8] : (is_write ? f_data : 8'h00);
  // Write data waits for the FIFO: the clock simply stretches low
  assign f_pop    = (state == HOST_LOAD) && (bit_idx == 3'd7) && in_data && is_write && f_valid;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= HOST_IDLE;
      link.slave_select_low <= 1'b1;
      link.serial_clk <= MODE3;
      link.mosi <= 1'b0;
      cmd_ready <= 1'b0;
      hdr <= '0;
      byte_pos <= '0;
      last_pos <= '0;
      bit_idx <= 3'd7;
      tx <= '0;
      rx <= '0;
      div <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      div <= div + 8'h01;
      unique case (state)
        HOST_IDLE:
        begin
          cmd_ready <= 1'b1;
          link.serial_clk <= MODE3;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            hdr <= {cmd_addr, cmd_direction_flag, cmd_count};
            last_pos <= 16'(cmd_count) + 16'(HDR_BYTES - 1);
            byte_pos <= '0;
            bit_idx <= 3'd7;
            link.slave_select_low <= 1'b0;
            link.mosi <= 1'b0;
            div <= '0;
            state <= HOST_SETUP;
          end
        end
        HOST_SETUP:
        begin
          if (div == 8'(HALF_CYCLES - 1))
          begin
            state <= HOST_LOAD;
          end
        end
        HOST_LOAD:
        begin
          link.serial_clk <= 1'b0;
          div <= '0;
          if (bit_idx != 3'd7)
          begin
            link.mosi <= tx[bit_idx];
            state <= HOST_LOW;
          end
          else if (!(in_data && is_write) || f_valid)
          begin
            tx <= new_byte;
            link.mosi <= new_byte[7];
            state <= HOST_LOW;
          end
        end
        HOST_LOW:
        begin
          if (div == 8'(HALF_CYCLES - 1))
          begin
            link.serial_clk <= 1'b1;
            div <= '0;
            state <= HOST_HIGH;
          end
        end
        HOST_HIGH:
        begin
          if (div == 8'(HALF_CYCLES - 1))
          begin
            rx <= {rx[5:0], miso_s2};
            div <= '0;
            bit_idx <= bit_idx - 3'd1;
            state <= HOST_LOAD;
            if (bit_idx == 3'd0)
            begin
              byte_pos <= byte_pos + 16'h0001;
              if (in_data && !is_write)
              begin
                rd_data <= {rx, miso_s2};
                rd_valid <= 1'b1;
              end
              if (byte_pos == last_pos)
              begin
                link.serial_clk <= MODE3;
                state <= HOST_END;
              end
            end
          end
        end
        HOST_END:
        begin
          if (div == 8'(HALF_CYCLES - 1))
          begin
            link.slave_select_low <= 1'b1;
            link.mosi <= 1'b0;
            done <= 1'b1;
            state <= HOST_IDLE;
          end
        end
        default:
        begin
          state <= HOST_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: spi_frame_device.sv */
// Slave device end: framed access to a local byte store
`timescale 1ns/1ps
module spi_frame_device import spi_frame_pkg::*; #(
  parameter int MEM_AW = 8
)(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  spi_frame_if.device        link,
  output logic [ADDR_W-1:0]  wr_addr,
  output logic [BYTE_W-1:0]  wr_data,
  output logic               wr_strobe,
  output logic               frame_busy,
  output logic               frame_abort
);
  logic [BYTE_W-1:0]  mem [2**MEM_AW];
  dev_state_t         state;
  logic [2:0]         bit_cnt;
  logic [6:0]         rx_shift;
  logic [1:0]         hdr_idx;
  logic [ADDR_W-1:0]  cur_addr;
  logic               direction_flag;
  logic [6:0]         count_hi;
  logic [COUNT_W-1:0] remaining;
  logic [7:0]         tx;
  logic [7:0]         rx_byte;
  logic               byte_done;
  logic               write_byte;

  // Link-side event holders, cleared by system reset, never by select; owed also clears once the count is met
  logic               wr_tgl;
  logic [ADDR_W-1:0]  lat_addr;
  logic [BYTE_W-1:0]  lat_data;
  logic               owed;

  // System-side synchronisers
  logic               tgl_s1;
  logic               tgl_s2;
  logic               tgl_s3;
  logic               sel_s1;
  logic               sel_s2;
  logic               sel_s3;
  logic               owed_s1;
  logic               owed_s2;

  // ----------------------------------------------------------------
  // Serial receive, link clock domain
  // ----------------------------------------------------------------
  assign rx_byte    = {rx_shift, link.mosi};
  assign byte_done  = bit_cnt == 3'd7;
  assign write_byte = byte_done && (state == DEV_DATA) && (direction_flag == DIR_WRITE);

  // Select high clears the frame logic: the clock may stop mid-frame,
  // so only the frame's own signal can end it
  always_ff @(posedge link.serial_clk or posedge link.slave_select_low)
  begin
    if (link.slave_select_low)
    begin
      bit_cnt  <= 3'd0;
      rx_shift <= 7'h00;
    end
    else
    begin
      bit_cnt  <= bit_cnt + 3'd1;
      rx_shift <= {rx_shift[5:0], link.mosi};
    end
  end

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  always_ff @(posedge link.serial_clk or posedge link.slave_select_low)
  begin
    if (link.slave_select_low)
    begin
      state          <= DEV_HDR;
      hdr_idx        <= 2'h0;
      cur_addr       <= '0;
      direction_flag <= DIR_READ;
      count_hi       <= 7'h00;
      remaining      <= '0;
    end
    else if (byte_done)
    begin
      unique case (state)
        DEV_HDR:
        begin
          hdr_idx <= hdr_idx + 2'h1;
          unique case (hdr_idx)
            HDR_ADDR_HI:
            begin
              cur_addr[15:8] <= rx_byte;
            end
            HDR_ADDR_LO:
            begin
              cur_addr[7:0] <= rx_byte;
            end
            HDR_FLAG_CNT:
            begin
              direction_flag <= rx_byte[DIR_BIT];
              count_hi       <= rx_byte[6:0];
            end
            HDR_CNT_LO:
            begin
              remaining <= {count_hi, rx_byte};
              // Zero count carries no data; treated as a finished frame
              state <= ({count_hi, rx_byte} == '0) ? DEV_DONE : DEV_DATA;
            end
          endcase
        end
        DEV_DATA:
        begin
          cur_addr  <= cur_addr + 16'h0001;
          remaining <= remaining - 15'h0001;
          if (remaining == 15'h0001)
          begin
            state <= DEV_DONE;
          end
        end
        DEV_DONE:
        begin
          state <= DEV_DONE;
        end
        default:
        begin
          state <= DEV_HDR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Byte store
  // ----------------------------------------------------------------
  always_ff @(posedge link.serial_clk)
  begin
    if (write_byte)
    begin
      mem[cur_addr[MEM_AW-1:0]] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Serial transmit on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge link.serial_clk or posedge link.slave_select_low)
  begin
    if (link.slave_select_low)
    begin
      tx <= 8'h00;
    end
    else if ((state == DEV_DATA) && (direction_flag == DIR_READ) && (bit_cnt == 3'd0))
    begin
      tx <= mem[cur_addr[MEM_AW-1:0]];
    end
    else
    begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign link.miso = tx[7];
  // Enable must follow select at once; a clocked copy would miss the
  // first bit in mode 0, where no edge precedes the first sample
  assign link.miso_oe = ~link.slave_select_low;

  // ----------------------------------------------------------------
  // Events handed to the system clock
  // ----------------------------------------------------------------
  always_ff @(posedge link.serial_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_tgl   <= 1'b0;
      lat_addr <= '0;
      lat_data <= '0;
    end
    else if (write_byte)
    begin
      // Held for a whole byte time, far longer than the sync delay
      lat_addr <= cur_addr;
      lat_data <= rx_byte;
      wr_tgl   <= ~wr_tgl;
    end
  end

  always_ff @(posedge link.serial_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      owed <= 1'b0;
    end
    else if ((state == DEV_HDR) && (hdr_idx == 2'h0) && (bit_cnt == 3'd0))
    begin
      owed <= 1'b1;
    end
    else if (byte_done && (((state == DEV_HDR) && (hdr_idx == HDR_CNT_LO) && (rx_byte == 8'h00)
             && (count_hi == 7'h00)) || ((state == DEV_DATA) && (remaining == 15'h0001))))
    begin
      owed <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    tgl_s1  <= wr_tgl;
    tgl_s2  <= tgl_s1;
    sel_s1  <= link.slave_select_low;
    sel_s2  <= sel_s1;
    owed_s1 <= owed;
    owed_s2 <= owed_s1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tgl_s3      <= 1'b0;
      sel_s3      <= 1'b1;
      wr_addr     <= '0;
      wr_data     <= '0;
      wr_strobe   <= 1'b0;
      frame_busy  <= 1'b0;
      frame_abort <= 1'b0;
    end
    else
    begin
      tgl_s3      <= tgl_s2;
      sel_s3      <= sel_s2;
      wr_strobe   <= tgl_s2 ^ tgl_s3;
      frame_busy  <= ~sel_s2;
      frame_abort <= sel_s2 && !sel_s3 && owed_s2;
      if (tgl_s2 ^ tgl_s3)
      begin
        wr_addr <= lat_addr;
        wr_data <= lat_data;
      end
    end
  end
endmodule

/* File: spi_frame_properties.sv */
// Protocol checker for the wires between host and device ends
`timescale 1ns/1ps
module spi_frame_properties
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slave_select_low,
  input wire logic serial_clk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  // ----
  // Helpers
  // ----
  logic [15:0] bit_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Rising link edges within the current frame
  always_ff @(posedge clk)
  begin
    if (sys_rst || slave_select_low)
      bit_cnt <= 16'h0;
    else if ($rose(serial_clk))
      bit_cnt <= bit_cnt + 16'h1;
  end

  // ----
  // Properties
  // ----
  property p_released;
    slave_select_low |-> !miso_oe;
  endproperty
  a_released: assert property (p_released) else $error("data-out driven while deselected");

  property p_driven;
    !slave_select_low |-> miso_oe;
  endproperty
  a_driven: assert property (p_driven) else $error("data-out not driven while selected");

  property p_miso_low;
    $fell(slave_select_low) |-> !miso_line [*8];
  endproperty
  a_miso_low: assert property (p_miso_low) else $error("data-out not low after select");

  property p_mosi_low;
    $fell(slave_select_low) |-> !mosi;
  endproperty
  a_mosi_low: assert property (p_mosi_low) else $error("data-in not low at select");

  property p_mosi_edge;
    !slave_select_low && $changed(mosi) |-> !serial_clk;
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("data-in moved with clock high");

  property p_miso_edge;
    !slave_select_low && !$past(slave_select_low) && $changed(miso) |-> !serial_clk;
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("data-out moved with clock high");

  property p_idle_clk;
    slave_select_low && $past(slave_select_low) |-> $stable(serial_clk);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("link clock moved between frames");

  property p_whole_bytes;
    $rose(slave_select_low) |-> (bit_cnt[2:0] == 3'h0) && (bit_cnt >= 16'h20);
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame ended off a byte or short");

  c_long: cover property ($rose(slave_select_low) && bit_cnt > 16'h28);
  c_start: cover property ($fell(slave_select_low));
  c_read_one: cover property (!slave_select_low && miso_line);
endmodule

/* File: spi_slave_frame_access_bench.sv */
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module spi_slave_frame_access_bench
  import spi_frame_pkg::*;
;
  logic               clk = 1'b0;
  logic               sys_rst;
  logic               cmd_valid = 1'b0, cmd_ready, cmd_direction_flag = 1'b0;
  logic [ADDR_W-1:0]  cmd_addr = 16'h0, dev_wr_addr, b_wr_addr;
  logic [COUNT_W-1:0] cmd_count = 15'h0;
  logic               wr_valid = 1'b0, wr_ready, rd_valid, done;
  logic [BYTE_W-1:0]  wr_data = 8'h0, rd_data, dev_wr_data, b_wr_data;
  logic               dev_wr_strobe, b_wr_strobe, dev_abort, b_abort, dev_busy, b_busy;
  int                 err_count = 0, n_checks = 0, a_aborts = 0, b_aborts = 0;
  integer             seed = 32'h10f11995;
  logic [ADDR_W-1:0]  wq_a[$], bq_a[$];
  logic [BYTE_W-1:0]  wq_d[$], rq_d[$], bq_d[$], dat[$];

  // ----
  // Ends and checker
  // ----
  spi_frame_if link_a ();
  spi_frame_if link_b ();

  spi_frame_host spi_frame_host_inst (.clk(clk), .sys_rst(sys_rst), .link(link_a.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_direction_flag(cmd_direction_flag), .cmd_count(cmd_count),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
  spi_frame_device spi_frame_device_inst (.clk(clk), .sys_rst(sys_rst), .link(link_a.device), .wr_addr(dev_wr_addr),
    .wr_data(dev_wr_data), .wr_strobe(dev_wr_strobe), .frame_busy(dev_busy), .frame_abort(dev_abort));
  // Second device faces a hand-driven mode 3 link that may cut frames short
  spi_frame_device spi_frame_device_inst_b (.clk(clk), .sys_rst(sys_rst), .link(link_b.device), .wr_addr(b_wr_addr),
    .wr_data(b_wr_data), .wr_strobe(b_wr_strobe), .frame_busy(b_busy), .frame_abort(b_abort));
  spi_frame_properties spi_frame_properties_inst (.clk(clk), .sys_rst(sys_rst),
    .slave_select_low(link_a.slave_select_low), .serial_clk(link_a.serial_clk), .mosi(link_a.mosi),
    .miso(link_a.miso), .miso_oe(link_a.miso_oe), .miso_line(link_a.miso_line));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (dev_wr_strobe === 1'b1) begin wq_a.push_back(dev_wr_addr); wq_d.push_back(dev_wr_data); end
    if (b_wr_strobe === 1'b1) begin bq_a.push_back(b_wr_addr); bq_d.push_back(b_wr_data); end
    if (rd_valid === 1'b1) rq_d.push_back(rd_data);
    if (dev_abort === 1'b1) a_aborts++;
    if (b_abort === 1'b1) b_aborts++;
  end

  // ----
  // Tasks
  // ----
  function automatic logic [15:0] exp_addr(input logic [15:0] a, input int i);
    return a + i[15:0];
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic give_up();
    err_count++;
    $display("MISMATCH t=%0t wait bound used up", $time);
    print_verdict();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic run_cmd(input logic [15:0] a, input logic dir, input logic [14:0] cnt);
    int k;
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_direction_flag <= dir;
    cmd_count <= cnt;
    k = 0;
    do begin @(posedge clk); k++; end while (cmd_ready !== 1'b1 && k < 100);
    if (cmd_ready !== 1'b1) give_up();
    cmd_valid <= 1'b0;
    // Busy follows select through a two-stage sync and one register
    tick(4);
    `CHK(dev_busy, 1'b1)
    k = 0;
    do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 40000);
    if (done !== 1'b1) give_up();
    tick(8);
    `CHK(dev_busy, 1'b0)
  endtask

  task automatic push(input logic [7:0] d, input int gap);
    int k;
    wr_valid <= 1'b1;
    wr_data <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (wr_ready !== 1'b1 && k < 20000);
    if (wr_ready !== 1'b1) give_up();
    wr_valid <= 1'b0;
    tick(gap);
  endtask

  // Write then read back the same span; starves the FIFO so the link stalls when slow is set
  task automatic write_read(input logic [15:0] a, input int slow);
    fork
      run_cmd(a, DIR_WRITE, 15'(dat.size()));
      if (slow) begin tick(600); foreach (dat[i]) push(dat[i], 30); end
    join
    `CHK(wq_a.size(), dat.size())
    for (int i = 0; i < dat.size() && i < wq_a.size(); i++)
    begin
      `CHK(wq_a[i], exp_addr(a, i))
      `CHK(wq_d[i], dat[i])
    end
    wq_a.delete(); wq_d.delete();
    run_cmd(a, DIR_READ, 15'(dat.size()));
    `CHK(rq_d.size(), dat.size())
    for (int i = 0; i < dat.size() && i < rq_d.size(); i++) `CHK(rq_d[i], dat[i])
    `CHK(wq_a.size(), 0)
    rq_d.delete();
  endtask

  task automatic bang_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      link_b.serial_clk = 1'b0;
      link_b.mosi = b[i];
      #40 link_b.serial_clk = 1'b1;
      #40;
    end
  endtask

  // Mode 3 write frame, clock off the bench clock's phase; cut short when nbytes < cnt
  task automatic bang_frame(input logic [15:0] a, input logic [14:0] cnt, input int nbytes, input logic [7:0] d);
    #1.3 link_b.slave_select_low = 1'b0;
    link_b.mosi = 1'b0;
    #40 `CHK(link_b.miso_line, 1'b0)
    `CHK(b_busy, 1'b1)
    bang_byte(a[15:8]); bang_byte(a[7:0]); bang_byte({DIR_WRITE, cnt[14:8]}); bang_byte(cnt[7:0]);
    repeat (nbytes) bang_byte(d);
    link_b.slave_select_low = 1'b1;
    tick(8);
    `CHK(link_b.miso_oe, 1'b0)
    `CHK(b_busy, 1'b0)
    `CHK(bq_a.size(), 1)
    if (bq_a.size() == 1) begin `CHK(bq_a[0], a) `CHK(bq_d[0], d) end
    bq_a.delete(); bq_d.delete();
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    // Nonblocking at time zero so every link-side flop sees the reset edges
    sys_rst <= 1'b1;
    link_b.slave_select_low <= 1'b1;
    link_b.serial_clk <= 1'b1;
    link_b.mosi <= 1'b0;
    tick(16);
    sys_rst <= 1'b0;
    tick(2);
    // Fill the FIFO until refused, then a burst across the address wrap
    dat.delete();
    for (int i = 0; i < 16; i++) begin dat.push_back(8'($random(seed))); push(dat[i], 1); end
    #1 `CHK(wr_ready, 1'b0)
    @(posedge clk) wr_valid <= 1'b1;
    wr_data <= 8'hee;
    tick(4);
    wr_valid <= 1'b0;
    write_read(16'hfff8, 0);
    // Single bytes and short bursts with the FIFO starving the link
    for (int n = 0; n < 4; n++)
    begin
      dat.delete();
      repeat (1 + n % 3) dat.push_back(8'($random(seed)));
      write_read(16'($random(seed)), 1);
    end
    run_cmd(16'h0040, DIR_READ, 15'h0);
    `CHK(rq_d.size(), 0)
    `CHK(a_aborts, 0)
    bang_frame(16'h1234, 15'h1, 1, 8'h5a);
    bang_frame(16'h0a0b, 15'h3, 1, 8'hc3);
    `CHK(b_aborts, 1)
    bang_frame(16'h0077, 15'h1, 1, 8'h81);
    `CHK(b_aborts, 1)
    print_verdict();
  end
endmodule
